/* File: rtl/bcdac_core.sv */
`timescale 1ns/1ps
`include "bcdac_regs.svh"

module bcdac_core (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // accumulator operations from the processor core
  input  wire logic       op_load,
  input  wire logic       op_add,
  input  wire logic       op_add_adjust,
  input  wire logic [7:0] operand,
  // adjust register read
  input  wire logic       adj_read,
  // interrupt entry and return
  input  wire logic       int_entry,
  input  wire logic       interrupt_return,
  // results
  output logic      [7:0] acc_out,
  output logic            carry_flag,
  output logic            half_carry_flag,
  output logic      [7:0] decimal_adjust_value,
  output logic            adjust_valid
);

  // ----------------------------------------
  // correction function
  // ----------------------------------------
  function automatic logic [7:0] adj_of(input logic [7:0] a,
                                        input logic       cy,
                                        input logic       ac);
    logic [3:0] lo;
    logic [3:0] hi;
    logic [8:0] tmp;
    lo  = (ac || a[3:0] > `BCDAC_DIGIT_MAX) ? `BCDAC_DIGIT_FIX
                                             : `BCDAC_NIB_ZERO;
    tmp = {1'b0, a} + {5'h00, lo};
    // high digit judged after the low fix may have rippled into it
    hi  = (cy || tmp[8] || tmp[7:4] > `BCDAC_DIGIT_MAX) ? `BCDAC_DIGIT_FIX
                                                        : `BCDAC_NIB_ZERO;
    return {hi, lo};
  endfunction

  bcdac_pkg::bcdac_state_t st_reg;
  bcdac_pkg::bcdac_state_t st_next;

  logic [7:0] adj_now;
  logic [8:0] sum;
  logic [4:0] sum_lo;
  logic [7:0] addend;

  assign adj_now = adj_of(st_reg.acc, st_reg.carry, st_reg.half);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next           = st_reg;
    st_next.adj_valid = 1'b0;
    addend            = op_add_adjust ? adj_now : operand;
    sum               = {1'b0, st_reg.acc} + {1'b0, addend};
    sum_lo            = {1'b0, st_reg.acc[3:0]} + {1'b0, addend[3:0]};
    if (adj_read) begin
      // sampled from live state, never a copy from the add
      st_next.adj       = adj_now;
      st_next.adj_valid = 1'b1;
    end
    if (interrupt_return) begin
      {st_next.carry, st_next.half} = st_reg.saved_flags;
    end else if (int_entry) begin
      st_next.saved_flags = {st_reg.carry, st_reg.half};
    end else if (op_load) begin
      st_next.acc = operand;
    end else if (op_add) begin
      st_next.acc   = sum[7:0];
      st_next.carry = sum[8];
      st_next.half  = sum_lo[4];
    end else if (op_add_adjust) begin
      st_next.acc   = sum[7:0];
      // decimal carry: a high fix means the pair passed 99
      st_next.carry = st_reg.carry || (adj_now[7:4] != `BCDAC_NIB_ZERO);
      st_next.half  = sum_lo[4];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg.acc         <= `BCDAC_ACC_RST;
      st_reg.carry       <= 1'b0;
      st_reg.half        <= 1'b0;
      st_reg.adj         <= `BCDAC_ADJ_RST;
      st_reg.adj_valid   <= 1'b0;
      st_reg.saved_flags <= `BCDAC_FLAGS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign acc_out              = st_reg.acc;
  assign carry_flag           = st_reg.carry;
  assign half_carry_flag      = st_reg.half;
  assign decimal_adjust_value = st_reg.adj;
  assign adjust_valid         = st_reg.adj_valid;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic plain_add;
  logic plain_adj;
  logic plain_load;
  logic no_op;
  assign plain_add = op_add && !interrupt_return && !int_entry && !op_load;
  assign plain_adj = op_add_adjust && !interrupt_return && !int_entry &&
                     !op_load && !op_add;
  assign plain_load = op_load && !interrupt_return && !int_entry;
  assign no_op = !op_load && !op_add && !op_add_adjust &&
                 !int_entry && !interrupt_return;

  // ----------------------------------------
  // checker helpers
  // ----------------------------------------
  function automatic logic is_bcd(input logic [7:0] b);
    return (b[7:4] <= `BCDAC_DIGIT_MAX) && (b[3:0] <= `BCDAC_DIGIT_MAX);
  endfunction

  // decimal worth of a packed pair, tens in the high nibble
  function automatic logic [7:0] dec_of(input logic [7:0] b);
    return ({4'h0, b[7:4]} * 8'h0a) + {4'h0, b[3:0]};
  endfunction

  // ----------------------------------------
  // operation sequences
  // ----------------------------------------
  sequence s_bin_add;
    plain_add;
  endsequence

  sequence s_fix_add;
    plain_adj;
  endsequence

  // decimal claims only hold for packed decimal operands
  sequence s_load;
    plain_load && is_bcd(operand);
  endsequence

  sequence s_bcd_add;
    plain_add && is_bcd(operand);
  endsequence

  sequence s_gap;
    no_op;
  endsequence

  sequence s_dec_run;
    s_load ##1 s_bcd_add ##1 s_gap ##1 s_fix_add;
  endsequence

  // ----------------------------------------
  // adjust register
  // ----------------------------------------
  a_adj_live: assert property (adj_read |=> adjust_valid &&
      decimal_adjust_value == adj_of($past(acc_out), $past(carry_flag),
                                     $past(half_carry_flag)))
    else $error("adjust value not from live state");

  a_adj_pulse: assert property (!adj_read |=> !adjust_valid)
    else $error("adjust valid without read");

  a_adj_hold: assert property (!adj_read |=>
      decimal_adjust_value == $past(decimal_adjust_value))
    else $error("adjust value moved without read");

  a_low_six: assert property (adj_read && half_carry_flag |=>
      decimal_adjust_value[3:0] == 4'h6)
    else $error("low fix missing");

  a_low_over: assert property (adj_read && acc_out[3:0] > 4'h9 |=>
      decimal_adjust_value[3:0] == 4'h6)
    else $error("low fix missing for large digit");

  a_low_zero: assert property (adj_read && !half_carry_flag &&
      acc_out[3:0] <= 4'h9 |=> decimal_adjust_value[3:0] == 4'h0)
    else $error("low fix without cause");

  a_high_six: assert property (adj_read && carry_flag |=>
      decimal_adjust_value[7:4] == 4'h6)
    else $error("high fix missing");

  a_high_over: assert property (adj_read && acc_out[7:4] > 4'h9 |=>
      decimal_adjust_value[7:4] == 4'h6)
    else $error("high fix missing for large digit");

  // a high digit of eight or less stays within nine after the low fix
  a_high_zero: assert property (adj_read && !carry_flag &&
      acc_out[7:4] <= 4'h8 |=> decimal_adjust_value[7:4] == 4'h0)
    else $error("high fix without cause");

  // ----------------------------------------
  // accumulator and flags
  // ----------------------------------------
  a_load_acc: assert property (plain_load |=> acc_out == $past(operand) &&
      $stable({carry_flag, half_carry_flag}))
    else $error("load wrong");

  a_idle_hold: assert property (no_op |=>
      $stable({acc_out, carry_flag, half_carry_flag}))
    else $error("state moved without an operation");

  a_sum_kept: assert property (s_bin_add |=> acc_out ==
      8'($past(acc_out) + $past(operand)))
    else $error("binary sum not kept");

  a_sum_carry: assert property (s_bin_add |=> carry_flag ==
      ({1'b0, $past(acc_out)} + {1'b0, $past(operand)} > 9'h0ff))
    else $error("binary carry wrong");

  a_sum_half: assert property (s_bin_add |=> half_carry_flag ==
      ({1'b0, $past(acc_out[3:0])} + {1'b0, $past(operand[3:0])} > 5'h0f))
    else $error("binary half carry wrong");

  a_fix_byte: assert property (s_fix_add |=>
      acc_out == 8'($past(acc_out) +
      adj_of($past(acc_out), $past(carry_flag), $past(half_carry_flag))))
    else $error("corrected byte wrong");

  a_decimal_digits: assert property (s_dec_run |=>
      acc_out[3:0] <= 4'h9 && acc_out[7:4] <= 4'h9)
    else $error("result not decimal");

  a_decimal_value: assert property (s_dec_run |=>
      {1'b0, dec_of(acc_out)} + (carry_flag ? 9'h064 : 9'h000) ==
      {1'b0, dec_of($past(operand, 4))} + {1'b0, dec_of($past(operand, 3))})
    else $error("decimal sum wrong");

  // ----------------------------------------
  // interrupt entry and return
  // ----------------------------------------
  a_flag_save: assert property (int_entry && !interrupt_return |=>
      st_reg.saved_flags == $past({carry_flag, half_carry_flag}))
    else $error("flags not saved");

  a_flag_restore: assert property (interrupt_return |=>
      {carry_flag, half_carry_flag} == $past(st_reg.saved_flags))
    else $error("flags not restored");

  a_ret_acc: assert property (interrupt_return |=>
      acc_out == $past(acc_out))
    else $error("accumulator moved on return");

endmodule

/* File: rtl/bcdac_regs.svh */
`ifndef BCDAC_REGS_SVH
`define BCDAC_REGS_SVH

// ----------------------------------------
// reset values and digit constants
// ----------------------------------------
`define BCDAC_ACC_RST    8'h00
`define BCDAC_ADJ_RST    8'h00
`define BCDAC_DIGIT_MAX  4'h9
`define BCDAC_DIGIT_FIX  4'h6
`define BCDAC_NIB_ZERO   4'h0
`define BCDAC_FLAGS_RST  2'h0

`endif

/* File: rtl/bcdac_pkg.sv */
package bcdac_pkg;

  // ----------------------------------------
  // state of the corrector
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] acc;
    logic       carry;
    logic       half;
    logic [7:0] adj;
    logic       adj_valid;
    logic [1:0] saved_flags;
  } bcdac_state_t;

endpackage

/* File: dv/bcdac_cpu.sv */
`timescale 1ns/1ps
module bcdac_cpu (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // request from the bench
  input  wire logic       go,
  input  wire logic [7:0] a_val,
  input  wire logic [7:0] b_val,
  // strobes and operand to the corrector, busy back to the bench
  output logic            op_load,
  output logic            op_add,
  output logic            adj_read,
  output logic            op_add_adjust,
  output logic      [7:0] operand,
  output logic            busy
);
  logic [3:0] seq_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seq_reg <= 4'h0;
    end else begin
      seq_reg <= {seq_reg[2:0], go & ~busy};
    end
  end
  assign op_load       = seq_reg[0];
  assign op_add        = seq_reg[1];
  assign adj_read      = seq_reg[2];
  assign op_add_adjust = seq_reg[3];
  // unused operand cycles carry junk, not a stale value
  assign operand = op_load ? a_val : (op_add ? b_val : ~b_val);
  assign busy    = |seq_reg;
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        go = 1'b0;
  logic        int_entry = 1'b0;
  logic        interrupt_return = 1'b0;
  logic  [7:0] a_val = 8'h00;
  logic  [7:0] b_val = 8'h00;
  logic        op_load, op_add, op_add_adjust, adj_read, busy, adjust_valid;
  logic        carry_flag, half_carry_flag;
  logic  [7:0] operand, acc_out, adj_val;
  logic [31:0] seed = 32'ha8fb;
  int          bad_count = 0;
  int          n_compared = 0;
  always #2.5 clk_sys = ~clk_sys;
  bcdac_cpu bcdac_cpu_inst (.clk_sys(clk_sys), .rst(rst), .go(go),
    .a_val(a_val), .b_val(b_val), .op_load(op_load), .op_add(op_add),
    .adj_read(adj_read), .op_add_adjust(op_add_adjust),
    .operand(operand), .busy(busy));
  bcdac_core bcdac_core_inst (.clk_sys(clk_sys), .rst(rst),
    .op_load(op_load), .op_add(op_add), .op_add_adjust(op_add_adjust),
    .operand(operand), .adj_read(adj_read), .int_entry(int_entry),
    .interrupt_return(interrupt_return), .acc_out(acc_out),
    .carry_flag(carry_flag), .half_carry_flag(half_carry_flag),
    .decimal_adjust_value(adj_val), .adjust_valid(adjust_valid));
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [7:0] bcd(input logic [7:0] r);
    return {4'(r[7:4] % 10), 4'(r[3:0] % 10)};
  endfunction
  function automatic logic [8:0] dec(input logic [7:0] a, b);
    int s;
    s = a[7:4] * 10 + a[3:0] + b[7:4] * 10 + b[3:0];
    return {s >= 100, 4'(s / 10 % 10), 4'(s % 10)};
  endfunction
  // correction is whatever turns the binary byte into the decimal byte
  function automatic logic [7:0] adjx(input logic [7:0] a, b);
    logic [8:0] d;
    d = dec(a, b);
    return d[7:0] - (a + b);
  endfunction
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // load, binary add, read, adjust add; bounded wait on busy
  task automatic run(input logic [7:0] a, input logic [7:0] b);
    int seen;
    seen = 0;
    @(posedge clk_sys);
    a_val <= a;
    b_val <= b;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      if (adj_read) cmp({carry_flag, acc_out}, 9'(a) + 9'(b));
      if (adjust_valid) cmp({1'b0, adj_val}, {1'b0, adjx(a, b)});
      seen += adjust_valid;
      if (!busy) begin
        cmp({carry_flag, acc_out}, dec(a, b));
        cmp(9'(seen), 9'h001);
        $display("test %h plus %h done", a, b);
        return;
      end
    end
    bad_count++;
    end_sim();
  endtask
  task automatic irq(input logic ret);
    @(posedge clk_sys);
    interrupt_return <= ret;
    int_entry <= ~ret;
    @(posedge clk_sys);
    interrupt_return <= 1'b0;
    int_entry <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    run(8'h99, 8'h89);
    run(8'h85, 8'h15);
    run(8'h80, 8'h80);
    run(8'h00, 8'h99);
    repeat (16) begin
      seed = nxt(seed);
      run(bcd(seed[7:0]), bcd(seed[15:8]));
    end
    run(8'h58, 8'h47);
    irq(1'b0);
    run(8'h01, 8'h02);
    run(8'h05, 8'h00);
    irq(1'b1);
    cmp({carry_flag, acc_out}, 9'h105);
    cmp({7'h00, carry_flag, half_carry_flag}, 9'h003);
    $display("test interrupt flag restore done");
    end_sim();
  end
endmodule
